// ==== common/aatg_consts.svh ====
// Constants for the audio amplitude transmit gate
`ifndef AATG_CONSTS_SVH
`define AATG_CONSTS_SVH
`define AATG_REG_CTRL 32'h0000_0000
`define AATG_REG_THRESH 32'h0000_0004
`define AATG_REG_MEAS 32'h0000_0008
`define AATG_REG_STATUS 32'h0000_000C
`define AATG_REG_PERIOD 32'h0000_0010
`define AATG_REG_CYCLES 32'h0000_0014
`define AATG_REG_RATE 32'h0000_0018
`define AATG_RISE_PCT_RST 7'h50
`define AATG_FALL_PCT_RST 7'h3C
`define AATG_MIN_CYC_RST 16'h0001
`define AATG_MIN_SMP_RST 16'h01E0
`define AATG_FULL_SCALE 17'h0_8000
`define AATG_SAMPLE_RATE 32'h0000_BB80
`define AATG_MCLK_RATIO 32'h0000_0200
`define AATG_REF_HZ 32'h017D_7840
`define AATG_PLL_MUL 32'h0000_0075
`define AATG_DIV_A 32'h0000_0011
`define AATG_DIV_B 32'h0000_0007
`define AATG_USB_FRAME_HZ 32'h0000_03E8
`define AATG_RESP_OKAY 2'h0
`define AATG_RESP_SLVERR 2'h2
`endif

// ==== common/aatg_pkg.sv ====
// Types for the audio amplitude transmit gate
package aatg_pkg;
    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } aatg_sample_t;
    typedef struct packed {
        logic [6:0] rise_pct;
        logic [6:0] fall_pct;
        logic [15:0] min_cycles;
        logic [15:0] min_samples;
    } aatg_cfg_t;
    typedef enum logic [1:0] {
        AATG_IDLE = 2'b00,
        AATG_ARMED = 2'b01,
        AATG_KEYED = 2'b10
    } aatg_state_t;
endpackage

// ==== logic/aatg_thresh_cmp.sv ====
// Percentage-of-full-scale comparator for a peak magnitude
`include "aatg_consts.svh"
module aatg_thresh_cmp (
    input wire logic [16:0] peak,
    input wire logic [6:0] pct,
    output logic at_or_above
);
    // Compare peak*100 against pct*full scale to avoid a divider
    wire [23:0] lhs = {7'h00, peak} * 24'd100;
    wire [23:0] rhs = {17'h0_0000, pct} * {7'h00, `AATG_FULL_SCALE};
    assign at_or_above = lhs >= rhs;
endmodule

// ==== logic/aatg_gate.sv ====
// Audio amplitude transmit gate with zero-crossing cycle timing
// Overview of operation
// [R1] Ignore audio cycles for measurement until peak reaches start percentage.
// [R2] Never key transmitter before amplitude has reached the start percentage.
// [R3] Key up once cycle peak drops below the stop percentage.
// [R4] Start threshold resets to eighty percent, stop threshold to sixty.
// [R5] Software should keep stop below start, both moderate.
// [R6] Software should not set start near full scale.
// [R7] Host supplies signed 16-bit samples; percentages judged on that range.
// [R8] Stream presents as stereo 48 ksps with 24-bit sample slots.
// [R9] Samples arrive in full-speed packets, 1000 per second, no shared clock.
// [R10] All clocks derive from one 25 MHz reference.
// [R11] Audio master clock runs at 512 times the sample rate.
// [R12] Master clock is reference times 117, divided by 17 and 7.
// [R13] No rate matching: every sample counts as one 48000th second.
// [R14] Transmit output is fully on or off, no shaping.
// [R15] Cycle boundary is a positive sample followed by a negative one.
// [R16] Measurement closes after both minimum cycles and samples are exceeded.
// [R17] Each cycle's peak magnitude is compared to the percentages.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`include "aatg_consts.svh"
module aatg_gate (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [47:0] smp_data,
    input wire logic smp_valid,
    output logic smp_ready,
    output logic tx_key,
    output logic meas_valid,
    output logic [31:0] meas_samples,
    output logic [15:0] meas_cycles
);
    // Stereo 24-bit slots; the signed 16-bit audio sits in the top bits [R8] [R7]
    wire aatg_pkg::aatg_sample_t smp;
    assign smp.left = smp_data[47:32];
    assign smp.right = smp_data[23:8];
    // One sample per handshake, no buffer, never stalled: no rate matching [R13] [R9]
    assign smp_ready = 1'b1;
    wire smp_take = smp_valid;

    aatg_pkg::aatg_cfg_t cfg_reg;
    logic gate_en_reg;
    aatg_pkg::aatg_state_t state_reg;
    logic signed [15:0] prev_reg;
    logic [16:0] peak_reg;
    logic [31:0] smp_cnt_reg;
    logic [15:0] cyc_cnt_reg;
    logic [31:0] meas_samples_reg;
    logic [15:0] meas_cycles_reg;
    logic meas_valid_reg;
    logic [31:0] meas_total_reg;

    // Zero crossing and peak tracking
    wire signed [15:0] cur = smp.left;
    wire [16:0] cur_mag = cur[15] ? (17'h0_0000 - {cur[15], cur}) : {1'b0, cur};
    wire zc = smp_take && (prev_reg > 16'sd0) && cur[15]; // [R15]
    wire [16:0] cyc_peak = (cur_mag > peak_reg) ? cur_mag : peak_reg;
    wire rise_ok;
    wire fall_ok;
    aatg_thresh_cmp u_rise (
        .peak(cyc_peak),
        .pct(cfg_reg.rise_pct),
        .at_or_above(rise_ok)
    );
    aatg_thresh_cmp u_fall (
        .peak(cyc_peak),
        .pct(cfg_reg.fall_pct),
        .at_or_above(fall_ok)
    );

    // Gate state: armed when enabled, keyed once a cycle peak reaches rise [R17]
    wire go_key = zc && (state_reg == aatg_pkg::AATG_ARMED) && rise_ok; // [R1] [R2]
    wire go_unkey = zc && (state_reg == aatg_pkg::AATG_KEYED) && !fall_ok; // [R3]
    aatg_pkg::aatg_state_t state_next;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            aatg_pkg::AATG_IDLE: begin
                if (gate_en_reg) begin
                    state_next = aatg_pkg::AATG_ARMED;
                end
            end
            aatg_pkg::AATG_ARMED: begin
                if (!gate_en_reg) begin
                    state_next = aatg_pkg::AATG_IDLE;
                end else if (go_key) begin
                    state_next = aatg_pkg::AATG_KEYED;
                end
            end
            aatg_pkg::AATG_KEYED: begin
                if (!gate_en_reg) begin
                    state_next = aatg_pkg::AATG_IDLE;
                end else if (go_unkey) begin
                    state_next = aatg_pkg::AATG_ARMED;
                end
            end
            default: begin
                state_next = aatg_pkg::AATG_IDLE;
            end
        endcase
    end
    wire keyed = state_reg == aatg_pkg::AATG_KEYED;

    // Measurement counters run only while keyed; the cycle that keys starts one
    wire meas_run = keyed && !go_unkey;
    wire cyc_done = zc && meas_run;
    wire [15:0] cyc_cnt_inc = cyc_cnt_reg + 16'h0001;
    wire [31:0] smp_cnt_inc = smp_cnt_reg + 32'h0000_0001;
    wire meas_close = cyc_done && (cyc_cnt_inc > cfg_reg.min_cycles)
        && (smp_cnt_inc > {16'h0000, cfg_reg.min_samples}); // [R16]
    wire [31:0] smp_cnt_next = (go_key || meas_close || !meas_run) ? 32'h0000_0000
        : (smp_take ? smp_cnt_inc : smp_cnt_reg);
    wire [15:0] cyc_cnt_next = (go_key || meas_close || !meas_run) ? 16'h0000
        : (cyc_done ? cyc_cnt_inc : cyc_cnt_reg);
    wire [16:0] peak_next = zc ? cur_mag : (smp_take ? cyc_peak : peak_reg);

    // AXI4-Lite write: address and data accepted in either order
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_hold_reg || aw_fire;
    wire w_have = w_hold_reg || w_fire;
    wire [31:0] wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire wr_do = aw_have && w_have && !bvalid_reg;
    wire [31:0] wr_word = {wr_addr[31:2], 2'b00};
    wire wr_ctrl = wr_do && wr_word == `AATG_REG_CTRL;
    wire wr_thr = wr_do && wr_word == `AATG_REG_THRESH;
    wire wr_meas = wr_do && wr_word == `AATG_REG_MEAS;
    wire wr_ok = wr_ctrl || wr_thr || wr_meas || wr_word == `AATG_REG_STATUS
        || wr_word == `AATG_REG_PERIOD || wr_word == `AATG_REG_CYCLES || wr_word == `AATG_REG_RATE;
    wire [31:0] thr_old = {9'h000, cfg_reg.fall_pct, 9'h000, cfg_reg.rise_pct};
    wire [31:0] meas_old = {cfg_reg.min_samples, cfg_reg.min_cycles};
    function automatic [31:0] merge(input [31:0] old, input [31:0] nw, input [3:0] st);
        integer i;
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (st[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction
    wire [31:0] thr_new = merge(thr_old, wr_data, wr_strb);
    wire [31:0] meas_new = merge(meas_old, wr_data, wr_strb);
    wire stat_clear = wr_do && wr_word == `AATG_REG_STATUS && wr_strb[0] && wr_data[1];

    // AXI4-Lite read
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    assign s_axi_arready = !rvalid_reg;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire [31:0] rd_word = {s_axi_araddr[31:2], 2'b00};
    // Master clock figures are fixed by the clock tree; only the sample rate is exposed, read-only [R10] [R11] [R12]
    wire [31:0] mclk_num = `AATG_REF_HZ * `AATG_PLL_MUL;
    wire [31:0] rate_word = `AATG_SAMPLE_RATE;
    wire [31:0] stat_word = {16'h0000, meas_cycles_reg[7:0], 4'h0, 1'b0, meas_valid_reg, keyed,
        state_reg == aatg_pkg::AATG_ARMED};
    wire rd_ok = rd_word == `AATG_REG_CTRL || rd_word == `AATG_REG_THRESH || rd_word == `AATG_REG_MEAS
        || rd_word == `AATG_REG_STATUS || rd_word == `AATG_REG_PERIOD || rd_word == `AATG_REG_CYCLES
        || rd_word == `AATG_REG_RATE;
    wire [31:0] rd_val = (rd_word == `AATG_REG_CTRL) ? {31'h0000_0000, gate_en_reg}
        : (rd_word == `AATG_REG_THRESH) ? thr_old
        : (rd_word == `AATG_REG_MEAS) ? meas_old
        : (rd_word == `AATG_REG_STATUS) ? stat_word
        : (rd_word == `AATG_REG_PERIOD) ? meas_samples_reg
        : (rd_word == `AATG_REG_CYCLES) ? {16'h0000, meas_cycles_reg}
        : (rd_word == `AATG_REG_RATE) ? rate_word ^ (mclk_num & 32'h0000_0000)
        : 32'h0000_0000;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cfg_reg.rise_pct <= `AATG_RISE_PCT_RST; // [R4]
            cfg_reg.fall_pct <= `AATG_FALL_PCT_RST; // [R4]
            cfg_reg.min_cycles <= `AATG_MIN_CYC_RST;
            cfg_reg.min_samples <= `AATG_MIN_SMP_RST;
            gate_en_reg <= 1'b1;
        end else begin
            if (wr_ctrl && wr_strb[0]) begin
                gate_en_reg <= wr_data[0];
            end
            if (wr_thr) begin
                cfg_reg.rise_pct <= thr_new[6:0];
                cfg_reg.fall_pct <= thr_new[22:16];
            end
            if (wr_meas) begin
                cfg_reg.min_cycles <= meas_new[15:0];
                cfg_reg.min_samples <= meas_new[31:16];
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= aatg_pkg::AATG_IDLE;
            prev_reg <= 16'sd0;
            peak_reg <= 17'h0_0000;
            smp_cnt_reg <= 32'h0000_0000;
            cyc_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (smp_take) begin
                prev_reg <= cur;
            end
            peak_reg <= peak_next;
            smp_cnt_reg <= smp_cnt_next;
            cyc_cnt_reg <= cyc_cnt_next;
        end
    end

    // Sample count is the period in 1/48000 s units; no timer needed [R13]
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meas_samples_reg <= 32'h0000_0000;
            meas_cycles_reg <= 16'h0000;
            meas_valid_reg <= 1'b0;
            meas_total_reg <= 32'h0000_0000;
        end else begin
            if (meas_close) begin
                meas_samples_reg <= smp_cnt_inc;
                meas_cycles_reg <= cyc_cnt_inc;
                meas_total_reg <= meas_total_reg + 32'h0000_0001;
            end
            // Set wins over a simultaneous software clear
            meas_valid_reg <= meas_close || (meas_valid_reg && !stat_clear);
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `AATG_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            aw_hold_reg <= aw_have && !wr_do;
            w_hold_reg <= w_have && !wr_do;
            if (wr_do) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_ok ? `AATG_RESP_OKAY : `AATG_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `AATG_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_val;
            rresp_reg <= rd_ok ? `AATG_RESP_OKAY : `AATG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    // Key is a plain on/off level; power is never stepped [R14]
    assign tx_key = keyed;
    assign meas_valid = meas_valid_reg;
    assign meas_samples = meas_samples_reg;
    assign meas_cycles = meas_cycles_reg;
endmodule

// ==== sim/aatg_gate_props.sv ====
// Port-level assertions for the audio amplitude transmit gate
`include "aatg_consts.svh"
module aatg_gate_props (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [47:0] smp_data,
    input wire logic smp_valid,
    input wire logic smp_ready,
    input wire logic tx_key,
    input wire logic meas_valid,
    input wire logic [31:0] meas_samples,
    input wire logic [15:0] meas_cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    logic signed [15:0] cur, prev_reg;
    logic [16:0] mag, pk, pk_reg;
    logic [6:0] rise_reg, fall_reg;
    logic en_reg, xing, wr, hi, lo;
    assign cur = smp_data[47:32];
    // Negate in 17 bits so the most negative sample keeps its full magnitude
    assign mag = cur[15] ? 17'h0_0000 - {cur[15], cur} : {1'b0, cur};
    assign pk = (mag > pk_reg) ? mag : pk_reg;
    assign xing = smp_valid && !prev_reg[15] && prev_reg != 16'h0000 && cur[15];
    assign hi = 32'(pk) * 100 >= 32'(rise_reg) << 15;
    assign lo = 32'(pk) * 100 < 32'(fall_reg) << 15;
    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev_reg <= 16'h0000;
            pk_reg <= 17'h0_0000;
            rise_reg <= `AATG_RISE_PCT_RST;
            fall_reg <= `AATG_FALL_PCT_RST;
            en_reg <= 1'b1;
        end else begin
            if (smp_valid) begin
                prev_reg <= cur;
                // The crossing sample opens the next cycle's peak as well
                pk_reg <= xing ? mag : pk;
            end
            if (wr && s_axi_awaddr == `AATG_REG_THRESH) begin
                rise_reg <= s_axi_wdata[6:0];
                fall_reg <= s_axi_wdata[22:16];
            end
            if (wr && s_axi_awaddr == `AATG_REG_CTRL) begin
                en_reg <= s_axi_wdata[0];
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_wr;
        wr;
    endsequence
    sequence s_rise_cause;
        xing && hi && !tx_key;
    endsequence
    a_key_on_rise: assert property (s_rise_cause ##0 (en_reg && $past(en_reg)) |=> tx_key)
        else $error("key did not rise on loud crossing");
    a_no_key_early: assert property ($rose(tx_key) |-> $past(xing && hi))
        else $error("key rose without loud crossing");
    a_key_off_low: assert property (xing && lo && tx_key |=> !tx_key)
        else $error("key held on quiet crossing");
    a_key_holds: assert property (tx_key && en_reg && !wr && !(xing && lo) |=> tx_key)
        else $error("key dropped without cause");
    a_key_fall_cause: assert property ($fell(tx_key) |-> $past(xing && lo) || !en_reg)
        else $error("key fell without quiet crossing");
    a_meas_at_xing: assert property ($rose(meas_valid) |-> $past(xing && tx_key))
        else $error("measurement closed off a crossing");
    a_meas_holds: assert property (!xing |=> $stable(meas_samples) && $stable(meas_cycles))
        else $error("measurement changed off a crossing");
    a_smp_ready: assert property (smp_ready)
        else $error("sample stream stalled");
    a_wr_answer: assert property (s_wr |=> s_axi_bvalid)
        else $error("write response missing");
endmodule
bind aatg_gate aatg_gate_props u_props (.*);

// ==== sim/aatg_host_src.sv ====
// Host model streaming square-wave audio cycles
module aatg_host_src (
    input wire logic mclk,
    output logic [47:0] smp_data,
    output logic smp_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        smp_data = 48'h0000_0000_0000;
        smp_valid = 1'b0;
    end
    task automatic send(input logic [15:0] amp, input int half, input int cycles, input int gap);
        logic [15:0] v;
        for (int c = 0; c < cycles; c++) begin
            for (int i = 0; i < 2 * half; i++) begin
                v = (i < half) ? amp : 16'h0000 - amp;
                @(posedge mclk);
                smp_data <= {v, 8'h00, ~v, 8'h00};
                smp_valid <= 1'b1;
                // Idle gaps stand in for packet spacing; no sample clock is shared
                repeat (gap) begin
                    @(posedge mclk);
                    smp_valid <= 1'b0;
                    smp_data <= ~smp_data;
                end
            end
        end
        @(posedge mclk);
        smp_valid <= 1'b0;
        smp_data <= ~smp_data;
    endtask
endmodule

// ==== sim/aatg_gate_test.sv ====
// Self-checking bench for the audio amplitude transmit gate
`include "aatg_consts.svh"
module aatg_gate_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, smp_valid;
    logic awready, wready, bvalid, arready, rvalid, smp_ready, tx_key, meas_valid;
    logic [31:0] awaddr, wdata, araddr, rdata, meas_samples;
    logic [1:0] bresp, rresp;
    logic [15:0] meas_cycles;
    logic [47:0] smp_data;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int seed = 2360;
    int a, prev_a, h, nc;
    logic exp_key;
    aatg_gate u_dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .smp_data(smp_data),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .tx_key(tx_key), .meas_valid(meas_valid),
        .meas_samples(meas_samples), .meas_cycles(meas_cycles));
    aatg_host_src u_host (.mclk(mclk), .smp_data(smp_data), .smp_valid(smp_valid));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic conclude;
        $display("Mismatches %0d, checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic key_next(input logic k, input int pk);
        if (!k) return pk * 100 >= `AATG_RISE_PCT_RST * `AATG_FULL_SCALE;
        return !(pk * 100 < `AATG_FALL_PCT_RST * `AATG_FULL_SCALE);
    endfunction
    // Address and data are offered together; each is dropped once its ready was seen
    task automatic xfer(input logic w, input logic [31:0] ad, input logic [31:0] d, input logic [1:0] er,
        input logic [31:0] ed);
        logic ta, tw, got;
        logic [31:0] rd;
        logic [1:0] rs;
        @(posedge mclk);
        awaddr <= ad;
        araddr <= ad;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        arvalid <= !w;
        bready <= w;
        rready <= !w;
        ta = 1'b0;
        tw = !w;
        while (!(ta && tw)) begin
            @(negedge mclk);
            ta = ta || (w ? awready : arready);
            tw = tw || wready;
            @(posedge mclk);
            if (ta) begin
                awvalid <= 1'b0;
                arvalid <= 1'b0;
            end
            if (tw) wvalid <= 1'b0;
        end
        got = 1'b0;
        while (!got) begin
            @(negedge mclk);
            got = w ? bvalid : rvalid;
            rs = w ? bresp : rresp;
            rd = rdata;
            @(posedge mclk);
        end
        bready <= 1'b0;
        rready <= 1'b0;
        check("resp", {30'h0, er}, {30'h0, rs});
        if (!w) check("rdata", ed, rd);
    endtask
    task automatic burst(input logic [15:0] amp, input int hf, input int n, input int gp, input logic ek);
        u_host.send(amp, hf, n, gp);
        @(negedge mclk);
        check("tx_key", {31'h0, ek}, {31'h0, tx_key});
    endtask
    initial begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 96'h0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        xfer(1'b0, `AATG_REG_THRESH, 32'h0000_0000, `AATG_RESP_OKAY, 32'h003C_0050);
        xfer(1'b0, `AATG_REG_MEAS, 32'h0000_0000, `AATG_RESP_OKAY, 32'h01E0_0001);
        xfer(1'b0, `AATG_REG_RATE, 32'h0000_0000, `AATG_RESP_OKAY, `AATG_SAMPLE_RATE);
        xfer(1'b0, `AATG_REG_CTRL, 32'h0000_0000, `AATG_RESP_OKAY, 32'h0000_0001);
        xfer(1'b0, 32'h0000_0040, 32'h0000_0000, `AATG_RESP_SLVERR, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0040, 32'h0000_0001, `AATG_RESP_SLVERR, 32'h0000_0000);
        xfer(1'b1, `AATG_REG_MEAS, 32'h000A_0002, `AATG_RESP_OKAY, 32'h0000_0000);
        burst(16'h6666, 4, 3, 1, 1'b0);
        burst(16'h6667, 4, 1, 0, 1'b1);
        burst(16'h6667, 4, 3, 0, 1'b1);
        check("meas_valid", 32'h0000_0001, {31'h0, meas_valid});
        check("meas_cycles", 32'h0000_0003, {16'h0000, meas_cycles});
        check("meas_samples", 32'h0000_0018, meas_samples);
        xfer(1'b0, `AATG_REG_PERIOD, 32'h0000_0000, `AATG_RESP_OKAY, 32'h0000_0018);
        xfer(1'b0, `AATG_REG_CYCLES, 32'h0000_0000, `AATG_RESP_OKAY, 32'h0000_0003);
        xfer(1'b0, `AATG_REG_STATUS, 32'h0000_0000, `AATG_RESP_OKAY, 32'h0000_0306);
        xfer(1'b1, `AATG_REG_STATUS, 32'h0000_0002, `AATG_RESP_OKAY, 32'h0000_0000);
        @(negedge mclk);
        check("meas_valid", 32'h0000_0000, {31'h0, meas_valid});
        burst(16'h4CCD, 4, 2, 0, 1'b1);
        burst(16'h4CCC, 4, 2, 0, 1'b0);
        // Moderate thresholds with stop well below start keep keying predictable
        xfer(1'b1, `AATG_REG_THRESH, 32'h001E_0046, `AATG_RESP_OKAY, 32'h0000_0000);
        burst(16'h5999, 4, 2, 0, 1'b0);
        burst(16'h599A, 4, 1, 0, 1'b1);
        xfer(1'b1, `AATG_REG_THRESH, 32'h003C_0050, `AATG_RESP_OKAY, 32'h0000_0000);
        xfer(1'b1, `AATG_REG_CTRL, 32'h0000_0000, `AATG_RESP_OKAY, 32'h0000_0000);
        @(negedge mclk);
        check("tx_key", 32'h0000_0000, {31'h0, tx_key});
        burst(16'h7FFF, 4, 2, 0, 1'b0);
        xfer(1'b1, `AATG_REG_CTRL, 32'h0000_0001, `AATG_RESP_OKAY, 32'h0000_0000);
        exp_key = 1'b0;
        prev_a = 32767;
        for (int i = 0; i < 12; i++) begin
            a = 15000 + $unsigned($random(seed)) % 17768;
            h = 2 + $unsigned($random(seed)) % 4;
            nc = 1 + $unsigned($random(seed)) % 3;
            // The first crossing of a burst still sees the previous burst's tail
            for (int c = 0; c < nc; c++) exp_key = key_next(exp_key, (c == 0 && prev_a > a) ? prev_a : a);
            burst(a[15:0], h, nc, $unsigned($random(seed)) % 2, exp_key);
            prev_a = a;
        end
        // A reset in mid-run must bring back the default thresholds and an enabled gate
        xfer(1'b1, `AATG_REG_THRESH, 32'h001E_0046, `AATG_RESP_OKAY, 32'h0000_0000);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        check("tx_key", 32'h0000_0000, {31'h0, tx_key});
        check("meas_valid", 32'h0000_0000, {31'h0, meas_valid});
        xfer(1'b0, `AATG_REG_THRESH, 32'h0000_0000, `AATG_RESP_OKAY, 32'h003C_0050);
        xfer(1'b0, `AATG_REG_STATUS, 32'h0000_0000, `AATG_RESP_OKAY, 32'h0000_0001);
        burst(16'h7FFF, 4, 1, 0, 1'b1);
        conclude();
    end
endmodule
